// ### core/lgr_regs.svh
// Register offsets, field positions, reset values and timing counts of the LED/GPIO/encoder unit.
// Included by the unit and by its bench; definitions only.
`ifndef LGR_REGS_SVH
`define LGR_REGS_SVH

`define LGR_ADDR_GLOBAL 8'h40
`define LGR_ADDR_DIR 8'h41
`define LGR_ADDR_INDEB 8'h42
`define LGR_ADDR_COMMON 8'h45
`define LGR_ADDR_ENC_CFG 8'h46
`define LGR_ADDR_TIMEOUT 8'h48
`define LGR_ADDR_INPUT 8'h49
`define LGR_ADDR_ENC_COUNT 8'h4A
`define LGR_ADDR_INTENS0 8'h50
`define LGR_ADDR_INTENS7 8'h57
`define LGR_ADDR_SETUP0 8'h58
`define LGR_ADDR_SETUP7 8'h5F

`define LGR_GL_ENC 7
`define LGR_GL_TOIRQ 5
`define LGR_GL_EN 4
`define LGR_EC_MODE 7
`define LGR_SU_COMMON 5

`define LGR_RST_REG 8'h00
`define LGR_FULL_ON 8'hFF
`define LGR_FADE_STEPS 5'h10
`define LGR_IN_DEB_BASE_MS 6'h09
`define LGR_ENC_DELAY_MS 9'h020
`define LGR_BLINK_BASE_MS 13'h0040
`define LGR_FADE_BASE_MS 12'h010

`define LGR_MS_NS 1000000
`define LGR_CLK_NS 20
`define LGR_MS_CYCLES (`LGR_MS_NS / `LGR_CLK_NS)

`endif

// ### core/lgr_pkg.sv
// Types shared by the LED/GPIO/encoder unit.
// Assumes lgr_regs.svh holds the numeric constants.
`default_nettype none
package lgr_pkg;
  typedef enum logic [1:0]
  {
    LGR_FADE_IDLE = 2'h0,
    LGR_FADE_UP = 2'h1,
    LGR_FADE_DOWN = 2'h3
  } lgr_fade_t;

  typedef enum logic [1:0]
  {
    LGR_IRQ_NONE = 2'h0,
    LGR_IRQ_RISE = 2'h1,
    LGR_IRQ_ANY = 2'h2
  } lgr_inirq_t;
endpackage
`default_nettype wire

// ### core/lgr_gpio_unit.sv
// Eight-line LED/GPIO unit with intensity modulation, fade, blink, input change
// interrupts and a two-line rotary encoder counter.
// Assumes a register port driven by a serial slave in the same clock domain.
`include "lgr_regs.svh"
`timescale 1ns/100ps
`default_nettype none

// Function
// RL1: Encoder config top bit: count or delay trigger
// RL2: Three-bit encoder trigger amount
// RL3: Encoder debounce zero to fifteen milliseconds
// RL4: Timeout flag bit zero, read clears
// RL5: Output ports read as one
// RL6: Input change seen after full debounce
// RL7: Input register ignores interrupt masking
// RL8: Signed wrapping encoder count
// RL9: Count read returns value then clears
// RL10: Intensity cycles of 256, FF full-on
// RL11: New intensity applied at period start
// RL12: Per-port interrupt: any, rising, none
// RL13: Per-port common or individual intensity
// RL14: Blink period field, zero disables
// RL15: Blink on-time 6.25 to 50 percent
// RL16: Blink periods share one timebase
// RL17: Fades take sixteen equal steps
// RL18: Common zero transitions fade common ports
// RL19: Wake fades in; individual write cancels
// RL20: Shutdown fades out; individual write cancels
// RL21: Interrupt from timeout, inputs, encoder
// RL22: Edge line rising counts by direction
// RL23: Global config: encoder, enable, fade
// RL24: Direction register, inputs at reset
// RL25: Periods staggered by one eighth
// RL26: Free-running eight-bit modulation counter
// RL27: Independent per-port fade state
module lgr_gpio_unit #(
  parameter int MS_CYCLES = `LGR_MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic busTimeout,
  input wire logic [7:0] ioLinesIn,
  output logic [7:0] ioLinesOut,
  output logic [7:0] ioLinesOe,
  output logic ioIrqOut_n
);

  localparam int MSW = $clog2(MS_CYCLES + 1);

  function automatic logic [7:0] scale(input logic [7:0] lvl, input logic [4:0] step);
    logic [12:0] prod;
    prod = 13'(lvl) * 13'(step);
    return prod[11:4];
  endfunction

  function automatic logic blinkOn(input logic [11:0] cnt, input logic [2:0] per,
                                   input logic [1:0] duty);
    logic [12:0] perMs;
    perMs = `LGR_BLINK_BASE_MS << (per - 3'h1);
    if (per == 3'h0)
      return 1'b1;
    return (({1'b0, cnt} & (perMs - 13'h0001)) < (perMs >> (3'h4 - {1'b0, duty})));
  endfunction

  // Timebase
  logic [7:0] pwmCnt_q, pwmCnt_d;
  logic [MSW-1:0] msCnt_q, msCnt_d;
  logic msTick_q, msTick_d;
  logic [11:0] blinkMs_q, blinkMs_d;
  logic [11:0] fadeMs_q, fadeMs_d;
  logic fadeTick;
  logic [11:0] stepMs;
  logic [2:0] fadeSel;

  // Registers and status
  logic [7:0] glb_q, glb_d, dir_q, dir_d, inDeb_q, inDeb_d, common_q, common_d;
  logic [7:0] encCfg_q, encCfg_d, rd_q, rd_d;
  logic [7:0] indiv_q [8];
  logic [7:0] indiv_d [8];
  logic [7:0] setup_q [8];
  logic [7:0] setup_d [8];
  logic toFlag_q, toFlag_d, encIrq_q, encIrq_d, irqN_q, irqN_d;
  logic [7:0] inIrq_q, inIrq_d;
  logic signed [7:0] encCount_q, encCount_d;
  logic [3:0] encAcc_q, encAcc_d;
  logic [8:0] encTimer_q, encTimer_d;
  logic encMode, encStep, encUp, rdIn, rdCount, rdTimeout;
  logic [7:0] dirEff, inView;
  logic [3:0] encThr;

  // Input path
  logic [7:0] sync1_q, sync2_q, stable_q, stable_d, chg;
  logic [5:0] debCnt_q [8];
  logic [5:0] debCnt_d [8];
  logic [5:0] debPer;

  // Per-port intensity
  lgr_pkg::lgr_fade_t fadeSt_q [8];
  lgr_pkg::lgr_fade_t fadeSt_d [8];
  logic [4:0] fadeStep_q [8];
  logic [4:0] fadeStep_d [8];
  logic [7:0] fadeBase_q [8];
  logic [7:0] fadeBase_d [8];
  logic [7:0] applied_q [8];
  logic [7:0] applied_d [8];
  logic [7:0] lvl [8];
  logic [7:0] tgt [8];
  logic [7:0] blink_q, blink_d, oe_q, oe_d, phase;
  logic wrGlobal, wrCommon, enRise, enFall, comToZero, comFromZero, fadeOn;

  // Timebase: one modulation counter, one millisecond tick
  always_comb
  begin
    pwmCnt_d = pwmCnt_q + 8'h01; // RL26
    msTick_d = (msCnt_q == MSW'(MS_CYCLES - 1));
    msCnt_d = msTick_d ? '0 : msCnt_q + MSW'(1);
    blinkMs_d = msTick_q ? blinkMs_q + 12'h001 : blinkMs_q; // RL16
    fadeSel = (glb_q[2:0] > 3'h5) ? 3'h5 : glb_q[2:0];
    stepMs = `LGR_FADE_BASE_MS << (fadeSel - 3'h1);
    fadeTick = msTick_q && (fadeSel != 3'h0) && (fadeMs_q >= stepMs - 12'h001);
    fadeMs_d = fadeTick ? 12'h000 : (msTick_q ? fadeMs_q + 12'h001 : fadeMs_q);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwmCnt_q <= 8'h00;
      msCnt_q <= '0;
      msTick_q <= 1'b0;
      blinkMs_q <= 12'h000;
      fadeMs_q <= 12'h000;
    end
    else
    begin
      pwmCnt_q <= pwmCnt_d;
      msCnt_q <= msCnt_d;
      msTick_q <= msTick_d;
      blinkMs_q <= blinkMs_d;
      fadeMs_q <= fadeMs_d;
    end
  end

  // Input synchronisers, then per-port debounce
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Idle level of a pulled-up line, so leaving reset makes no false edge
      sync1_q <= 8'hFF;
      sync2_q <= 8'hFF;
    end
    else
    begin
      sync1_q <= ioLinesIn;
      sync2_q <= sync1_q;
    end
  end

  always_comb
  begin
    encMode = glb_q[`LGR_GL_ENC];
    dirEff = encMode ? {2'b00, dir_q[5:0]} : dir_q; // RL24
    debPer = 6'h00;
    for (int i = 0; i < 8; i++)
    begin
      debPer = (encMode && i >= 6) ? {2'b00, encCfg_q[3:0]} // RL3
                                   : `LGR_IN_DEB_BASE_MS + {1'b0, inDeb_q[4:0]};
      stable_d[i] = stable_q[i];
      debCnt_d[i] = 6'h00;
      // While driven, follow the pin so turning it round raises nothing
      if (dirEff[i])
        stable_d[i] = sync2_q[i]; // RL6
      else if (sync2_q[i] != stable_q[i])
      begin
        if (debCnt_q[i] >= debPer)
          stable_d[i] = sync2_q[i]; // RL6
        else
          debCnt_d[i] = msTick_q ? debCnt_q[i] + 6'h01 : debCnt_q[i];
      end
      chg[i] = !dirEff[i] && (stable_d[i] != stable_q[i]);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      stable_q <= 8'hFF;
      for (int i = 0; i < 8; i++)
        debCnt_q[i] <= 6'h00;
    end
    else
    begin
      stable_q <= stable_d;
      for (int i = 0; i < 8; i++)
        debCnt_q[i] <= debCnt_d[i];
    end
  end

  // Register file, encoder counter and interrupt sources
  always_comb
  begin
    glb_d = glb_q;
    dir_d = dir_q;
    inDeb_d = inDeb_q;
    common_d = common_q;
    encCfg_d = encCfg_q;
    for (int i = 0; i < 8; i++)
    begin
      indiv_d[i] = indiv_q[i];
      setup_d[i] = setup_q[i];
    end
    if (regWrEn)
    begin
      if (regAddr == `LGR_ADDR_GLOBAL)
        glb_d = regWrData; // RL23
      else if (regAddr == `LGR_ADDR_DIR)
        dir_d = regWrData; // RL24
      else if (regAddr == `LGR_ADDR_INDEB)
        inDeb_d = regWrData;
      else if (regAddr == `LGR_ADDR_COMMON)
        common_d = regWrData;
      else if (regAddr == `LGR_ADDR_ENC_CFG)
        encCfg_d = regWrData;
      else if (regAddr >= `LGR_ADDR_INTENS0 && regAddr <= `LGR_ADDR_INTENS7)
        indiv_d[regAddr[2:0]] = regWrData;
      else if (regAddr >= `LGR_ADDR_SETUP0 && regAddr <= `LGR_ADDR_SETUP7)
        setup_d[regAddr[2:0]] = regWrData;
    end

    inView = stable_q | dirEff; // RL5 RL7
    rdIn = regRdEn && (regAddr == `LGR_ADDR_INPUT);
    rdCount = regRdEn && (regAddr == `LGR_ADDR_ENC_COUNT);
    rdTimeout = regRdEn && (regAddr == `LGR_ADDR_TIMEOUT);

    rd_d = 8'h00;
    if (regRdEn)
    begin
      if (regAddr == `LGR_ADDR_GLOBAL)
        rd_d = glb_q;
      else if (regAddr == `LGR_ADDR_DIR)
        rd_d = dir_q;
      else if (regAddr == `LGR_ADDR_INDEB)
        rd_d = inDeb_q;
      else if (regAddr == `LGR_ADDR_COMMON)
        rd_d = common_q;
      else if (regAddr == `LGR_ADDR_ENC_CFG)
        rd_d = encCfg_q;
      else if (regAddr == `LGR_ADDR_TIMEOUT)
        rd_d = {7'h00, toFlag_q}; // RL4
      else if (regAddr == `LGR_ADDR_INPUT)
        rd_d = inView;
      else if (regAddr == `LGR_ADDR_ENC_COUNT)
        rd_d = encCount_q; // RL9
      else if (regAddr >= `LGR_ADDR_INTENS0 && regAddr <= `LGR_ADDR_INTENS7)
        rd_d = indiv_q[regAddr[2:0]];
      else if (regAddr >= `LGR_ADDR_SETUP0 && regAddr <= `LGR_ADDR_SETUP7)
        rd_d = setup_q[regAddr[2:0]];
    end
    else
      rd_d = rd_q;

    // Flags: a new event in the clearing cycle survives
    toFlag_d = busTimeout || (toFlag_q && !rdTimeout); // RL4

    inIrq_d = rdIn ? 8'h00 : inIrq_q;
    for (int i = 0; i < 8; i++)
    begin
      if (!(encMode && i >= 6))
      begin
        case (setup_q[i][7:6]) // RL12
          lgr_pkg::LGR_IRQ_NONE: ;
          lgr_pkg::LGR_IRQ_RISE: if (chg[i] && stable_d[i]) inIrq_d[i] = 1'b1;
          default: if (chg[i]) inIrq_d[i] = 1'b1;
        endcase
      end
    end

    encStep = encMode && chg[6] && stable_d[6];
    encUp = !stable_q[7]; // RL22
    encCount_d = rdCount ? 8'sh00 : encCount_q; // RL9
    encAcc_d = rdCount ? 4'h0 : encAcc_q;
    encTimer_d = rdCount ? 9'h000 : encTimer_q;
    if (encStep)
    begin
      encCount_d = encUp ? encCount_d + 8'sh01 : encCount_d - 8'sh01; // RL8 RL22
      encAcc_d = (encAcc_d == 4'h8) ? 4'h8 : encAcc_d + 4'h1;
    end
    else if (msTick_q && encAcc_q != 4'h0 && encTimer_q != 9'h1FF && !rdCount)
      encTimer_d = encTimer_q + 9'h001;
    encThr = {1'b0, encCfg_q[6:4]} + 4'h1; // RL2
    encIrq_d = encIrq_q && !rdCount;
    if (encCfg_q[`LGR_EC_MODE]) // RL1
    begin
      if (encAcc_q != 4'h0 && encTimer_q >= 9'(encThr) * `LGR_ENC_DELAY_MS)
        encIrq_d = 1'b1;
    end
    else if (encAcc_q >= encThr)
      encIrq_d = 1'b1;
    if (rdCount)
      encIrq_d = encStep && (encThr == 4'h1) && !encCfg_q[`LGR_EC_MODE];

    irqN_d = !((|inIrq_q) || encIrq_q || (toFlag_q && glb_q[`LGR_GL_TOIRQ])); // RL21
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      glb_q <= `LGR_RST_REG;
      dir_q <= `LGR_RST_REG;
      inDeb_q <= `LGR_RST_REG;
      common_q <= `LGR_RST_REG;
      encCfg_q <= `LGR_RST_REG;
      rd_q <= 8'h00;
      for (int i = 0; i < 8; i++)
      begin
        indiv_q[i] <= `LGR_RST_REG;
        setup_q[i] <= `LGR_RST_REG;
      end
      toFlag_q <= 1'b0;
      inIrq_q <= 8'h00;
      encCount_q <= 8'sh00;
      encAcc_q <= 4'h0;
      encTimer_q <= 9'h000;
      encIrq_q <= 1'b0;
      irqN_q <= 1'b1;
    end
    else
    begin
      glb_q <= glb_d;
      dir_q <= dir_d;
      inDeb_q <= inDeb_d;
      common_q <= common_d;
      encCfg_q <= encCfg_d;
      rd_q <= rd_d;
      for (int i = 0; i < 8; i++)
      begin
        indiv_q[i] <= indiv_d[i];
        setup_q[i] <= setup_d[i];
      end
      toFlag_q <= toFlag_d;
      inIrq_q <= inIrq_d;
      encCount_q <= encCount_d;
      encAcc_q <= encAcc_d;
      encTimer_q <= encTimer_d;
      encIrq_q <= encIrq_d;
      irqN_q <= irqN_d;
    end
  end

  // Per-port fade, latch and modulation
  always_comb
  begin
    wrGlobal = regWrEn && (regAddr == `LGR_ADDR_GLOBAL);
    wrCommon = regWrEn && (regAddr == `LGR_ADDR_COMMON);
    enRise = wrGlobal && regWrData[`LGR_GL_EN] && !glb_q[`LGR_GL_EN];
    enFall = wrGlobal && !regWrData[`LGR_GL_EN] && glb_q[`LGR_GL_EN];
    comToZero = wrCommon && (regWrData == 8'h00) && (common_q != 8'h00);
    comFromZero = wrCommon && (regWrData != 8'h00) && (common_q == 8'h00);
    // A wake or shutdown write may carry the fade time in the same byte
    fadeOn = wrGlobal ? (regWrData[2:0] != 3'h0) : (glb_q[2:0] != 3'h0);
    for (int i = 0; i < 8; i++)
    begin
      tgt[i] = !glb_q[`LGR_GL_EN] ? 8'h00
             : (setup_q[i][`LGR_SU_COMMON] ? common_q : indiv_q[i]); // RL13
      case (fadeSt_q[i])
        lgr_pkg::LGR_FADE_UP: lvl[i] = scale(tgt[i], fadeStep_q[i]); // RL17
        lgr_pkg::LGR_FADE_DOWN: lvl[i] = scale(fadeBase_q[i], fadeStep_q[i]); // RL17
        default: lvl[i] = tgt[i];
      endcase
      fadeSt_d[i] = fadeSt_q[i];
      fadeStep_d[i] = fadeStep_q[i];
      fadeBase_d[i] = fadeBase_q[i];
      if (regWrEn && regAddr == `LGR_ADDR_INTENS0 + 8'(i) && fadeSt_q[i] != lgr_pkg::LGR_FADE_IDLE)
        fadeSt_d[i] = lgr_pkg::LGR_FADE_IDLE; // RL19 RL20
      else if (!fadeOn)
        fadeSt_d[i] = lgr_pkg::LGR_FADE_IDLE;
      else if (enFall || (comToZero && setup_q[i][`LGR_SU_COMMON] && glb_q[`LGR_GL_EN]))
      begin
        fadeSt_d[i] = lgr_pkg::LGR_FADE_DOWN; // RL18 RL20
        fadeBase_d[i] = lvl[i];
        fadeStep_d[i] = `LGR_FADE_STEPS;
      end
      else if (enRise || (comFromZero && setup_q[i][`LGR_SU_COMMON] && glb_q[`LGR_GL_EN]))
      begin
        fadeSt_d[i] = lgr_pkg::LGR_FADE_UP; // RL18 RL19
        fadeStep_d[i] = 5'h00;
      end
      else if (fadeTick)
      begin
        case (fadeSt_q[i]) // RL27
          lgr_pkg::LGR_FADE_UP:
          begin
            fadeStep_d[i] = fadeStep_q[i] + 5'h01;
            if (fadeStep_d[i] == `LGR_FADE_STEPS)
              fadeSt_d[i] = lgr_pkg::LGR_FADE_IDLE;
          end
          lgr_pkg::LGR_FADE_DOWN:
          begin
            fadeStep_d[i] = fadeStep_q[i] - 5'h01;
            if (fadeStep_d[i] == 5'h00)
              fadeSt_d[i] = lgr_pkg::LGR_FADE_IDLE;
          end
          default: ;
        endcase
      end
      // Each port latches at its own one-eighth offset
      applied_d[i] = applied_q[i];
      blink_d[i] = blink_q[i];
      if (pwmCnt_q == 8'(i * 32)) // RL11 RL25
      begin
        applied_d[i] = lvl[i];
        blink_d[i] = blinkOn(blinkMs_q, setup_q[i][4:2], setup_q[i][1:0]); // RL14 RL15 RL16
      end
      phase[i] = 1'b0;
      phase[i] = ((pwmCnt_q - 8'(i * 32)) < applied_q[i]); // RL10
      oe_d[i] = dirEff[i] && blink_q[i] && ((applied_q[i] == `LGR_FULL_ON) || phase[i]); // RL10
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        fadeSt_q[i] <= lgr_pkg::LGR_FADE_IDLE;
        fadeStep_q[i] <= 5'h00;
        fadeBase_q[i] <= 8'h00;
        applied_q[i] <= 8'h00;
      end
      blink_q <= 8'h00;
      oe_q <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        fadeSt_q[i] <= fadeSt_d[i];
        fadeStep_q[i] <= fadeStep_d[i];
        fadeBase_q[i] <= fadeBase_d[i];
        applied_q[i] <= applied_d[i];
      end
      blink_q <= blink_d;
      oe_q <= oe_d;
    end
  end

  // Open-drain lines only ever pull low
  assign ioLinesOut = 8'h00 & oe_q;
  assign ioLinesOe = oe_q;
  assign ioIrqOut_n = irqN_q;
  assign regRdData = rd_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_count_clear: assert property (rdCount && !encStep |=> encCount_q == 8'sh00) // RL9
    else $error("encoder count not cleared by read");
  chk_count_read: assert property (rdCount |=> rd_q == $past(encCount_q)) // RL9
    else $error("encoder count read wrong value");
  chk_count_up: assert property (encStep && encUp && !rdCount // RL22
    |=> encCount_q == $past(encCount_q) + 8'sh01)
    else $error("clockwise step did not increment");
  chk_out_reads_one: assert property (rdIn |=> (rd_q & $past(dirEff)) == $past(dirEff)) // RL5
    else $error("output port not read as one");
  chk_timeout_set: assert property (busTimeout |=> toFlag_q) // RL4
    else $error("timeout flag not set");
  chk_timeout_clr: assert property (rdTimeout && !busTimeout |=> !toFlag_q) // RL4
    else $error("timeout flag not cleared by read");
  chk_irq_inputs: assert property ((|inIrq_q) |=> !ioIrqOut_n) // RL21
    else $error("pending input change not on interrupt");
  chk_apply_edge: assert property (applied_q[2] != $past(applied_q[2]) // RL11
    |-> $past(pwmCnt_q) == 8'h40)
    else $error("intensity changed mid-period");
  chk_full_on: assert property (applied_q[0] == `LGR_FULL_ON && dirEff[0] && blink_q[0] // RL10
    |=> oe_q[0])
    else $error("full intensity not sinking");
  chk_zero_off: assert property (applied_q[3] == 8'h00 |=> !oe_q[3]) // RL10
    else $error("zero intensity sinking");
  chk_fade_range: assert property (fadeStep_q[5] <= `LGR_FADE_STEPS) // RL17
    else $error("fade step beyond sixteen");

  cov_enc_step: cover property (encStep ##1 rdCount);
  cov_fade_out: cover property (fadeSt_q[0] == lgr_pkg::LGR_FADE_DOWN
    ##1 fadeSt_q[0] == lgr_pkg::LGR_FADE_IDLE);
  cov_in_irq: cover property (!ioIrqOut_n ##1 rdIn);

endmodule

`default_nettype wire

// ### testbench/lgr_host_model.sv
// Host side of the register port: byte writes and reads as tasks.
// Assumes the unit samples the strobes on rising mclk; drives on falling.
`timescale 1ns/100ps
`default_nettype none
module lgr_host_model (
  input wire logic mclk,
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial
  begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge mclk);
    regWrEn = 1'b0;
  endtask

  // Data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// ### testbench/lgr_gpio_unit_bench.sv
// Self-checking bench for the LED/GPIO/encoder unit.
// Assumes open-drain lines with pull-ups and a short millisecond parameter.
`include "lgr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    cmpCount++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("BAD %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module lgr_gpio_unit_bench;
  localparam int MsCyc = 20;
  localparam int DebWait = 12 * MsCyc;
  localparam int Limit = 40000;
  logic mclk, rstn, busTimeout, regWrEn, regRdEn, ioIrqOut_n;
  logic [7:0] regAddr, regWrData, regRdData, ioLinesIn, ioLinesOut, ioLinesOe;
  logic [7:0] pins, rdv, dirv, v;
  logic [7:0] vals [4];
  int errors, cmpCount, cycles, cnt, n0, n1, seedVal;

  // Open drain with pull-up: the line is low wherever anyone sinks
  assign ioLinesIn = pins & ~ioLinesOe;

  lgr_gpio_unit #(.MS_CYCLES(MsCyc)) lgr_gpio_unit_i (.mclk(mclk), .rstn(rstn),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .busTimeout(busTimeout), .ioLinesIn(ioLinesIn),
    .ioLinesOut(ioLinesOut), .ioLinesOe(ioLinesOe), .ioIrqOut_n(ioIrqOut_n));
  lgr_host_model lgr_host_model_i (.mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  always #10 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == Limit)
    begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    lgr_host_model_i.wr(a, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    lgr_host_model_i.rd(a, rdv);
    `CHK(what, e, rdv)
  endtask

  task automatic irq_chk(input string what, input logic e);
    `CHK(what, e, ioIrqOut_n)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Counts sinking cycles of lines 0 and 1 over one modulation period
  task automatic count_on();
    n0 = 0;
    n1 = 0;
    repeat (256)
    begin
      @(negedge mclk);
      n0 += (ioLinesOe[0] === 1'b1);
      n1 += (ioLinesOe[1] === 1'b1);
    end
  endtask

  task automatic enc_step(input logic dirLine);
    pins[7] = dirLine;
    wait_cyc(2 * MsCyc);
    pins[6] = 1'b1;
    cnt += dirLine ? -1 : 1;
    wait_cyc(2 * MsCyc);
    pins[6] = 1'b0;
  endtask

  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    busTimeout = 1'b0;
    pins = 8'hFF;
    seedVal = $urandom(32'hDBE46831);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;

    // Reset values, read-back, refused places
    rd_chk("global", `LGR_ADDR_GLOBAL, 8'h00);
    rd_chk("direction", `LGR_ADDR_DIR, 8'h00);
    rd_chk("enc cfg", `LGR_ADDR_ENC_CFG, 8'h00);
    v = $urandom;
    wr(`LGR_ADDR_ENC_CFG, v);
    rd_chk("enc cfg rw", `LGR_ADDR_ENC_CFG, v);
    wr(8'h7F, 8'hA5);
    rd_chk("unmapped", 8'h7F, 8'h00);
    wr(`LGR_ADDR_INPUT, 8'h00);
    wr(`LGR_ADDR_ENC_CFG, 8'h00);
    wait_cyc(DebWait);
    rd_chk("levels idle", `LGR_ADDR_INPUT, 8'hFF);
    `CHK("drive", 8'h00, ioLinesOut)
    $display("test reset done");

    // Outputs read high; no event when an output turns back to input
    for (int i = 0; i < 8; i++)
      wr(`LGR_ADDR_SETUP0 + i[7:0], 8'h80);
    pins = $urandom;
    wait_cyc(DebWait);
    rd_chk("levels rand", `LGR_ADDR_INPUT, pins);
    dirv = $urandom;
    wr(`LGR_ADDR_DIR, dirv);
    rd_chk("levels dir", `LGR_ADDR_INPUT, pins | dirv);
    wr(`LGR_ADDR_DIR, 8'hFF);
    pins = ~pins;
    wait_cyc(DebWait);
    wr(`LGR_ADDR_DIR, 8'h00);
    wait_cyc(DebWait);
    irq_chk("no spurious", 1'b1);
    rd_chk("levels back", `LGR_ADDR_INPUT, pins);
    $display("test direction done");

    // Input change interrupts: any on line 0, rising on line 1
    for (int i = 2; i < 8; i++)
      wr(`LGR_ADDR_SETUP0 + i[7:0], 8'h00);
    wr(`LGR_ADDR_SETUP0 + 8'h01, 8'h40);
    pins = 8'hFF;
    wait_cyc(DebWait);
    rd_chk("clear", `LGR_ADDR_INPUT, 8'hFF);
    pins = 8'hFE;
    wait_cyc(3 * MsCyc);
    pins = 8'hFF;
    wait_cyc(DebWait);
    irq_chk("glitch", 1'b1);
    pins = 8'hFD;
    wait_cyc(DebWait);
    irq_chk("falling on rise", 1'b1);
    pins = 8'hFC;
    wait_cyc(DebWait);
    irq_chk("any edge", 1'b0);
    rd_chk("levels fc", `LGR_ADDR_INPUT, 8'hFC);
    wait_cyc(2);
    irq_chk("read clears", 1'b1);
    pins = 8'hFE;
    wait_cyc(DebWait);
    irq_chk("rising", 1'b0);
    rd_chk("levels fe", `LGR_ADDR_INPUT, 8'hFE);
    $display("test input irq done");

    // Bus timeout flag
    wr(`LGR_ADDR_GLOBAL, 8'h20);
    busTimeout = 1'b1;
    wait_cyc(1);
    busTimeout = 1'b0;
    wait_cyc(3);
    irq_chk("timeout irq", 1'b0);
    rd_chk("timeout flag", `LGR_ADDR_TIMEOUT, 8'h01);
    wait_cyc(2);
    irq_chk("timeout clear", 1'b1);
    rd_chk("timeout again", `LGR_ADDR_TIMEOUT, 8'h00);
    $display("test timeout done");

    // Encoder: count mode, one step, no debounce; wraps past +127
    wr(`LGR_ADDR_SETUP0 + 8'h01, 8'h00);
    pins = 8'h3F;
    wait_cyc(DebWait);
    rd_chk("enc lines", `LGR_ADDR_INPUT, 8'h3F);
    wr(`LGR_ADDR_GLOBAL, 8'h80);
    cnt = 0;
    enc_step(1'b0);
    wait_cyc(2 * MsCyc);
    irq_chk("enc irq", 1'b0);
    n0 = 128 + ($urandom % 8);
    repeat (n0)
      enc_step(1'b0);
    repeat (3)
      enc_step(1'b1);
    wait_cyc(2 * MsCyc);
    rd_chk("enc count", `LGR_ADDR_ENC_COUNT, cnt[7:0]);
    wait_cyc(2);
    irq_chk("enc clear", 1'b1);
    rd_chk("enc zero", `LGR_ADDR_ENC_COUNT, 8'h00);
    // Delay trigger: one step, interrupt only once 32 ms have passed
    wr(`LGR_ADDR_ENC_CFG, 8'h80);
    cnt = 0;
    enc_step(1'b0);
    irq_chk("enc delay early", 1'b1);
    wait_cyc(35 * MsCyc);
    irq_chk("enc delay late", 1'b0);
    rd_chk("enc delay count", `LGR_ADDR_ENC_COUNT, cnt[7:0]);
    $display("test encoder done");

    // Modulation: line 0 individual, line 1 common
    wr(`LGR_ADDR_GLOBAL, 8'h10);
    wr(`LGR_ADDR_DIR, 8'h03);
    wr(`LGR_ADDR_SETUP0 + 8'h01, 8'h20);
    v = $urandom;
    vals = '{v, 8'h00, 8'hFE, 8'hFF};
    for (int i = 0; i < 4; i++)
    begin
      wr(`LGR_ADDR_INTENS0, vals[i]);
      wr(`LGR_ADDR_COMMON, vals[3 - i]);
      wait_cyc(600);
      count_on();
      `CHK("on cycles 0", (vals[i] == 8'hFF) ? 256 : int'(vals[i]), n0)
      `CHK("on cycles 1", (vals[3 - i] == 8'hFF) ? 256 : int'(vals[3 - i]), n1)
    end
    wr(`LGR_ADDR_GLOBAL, 8'h00);
    wait_cyc(600);
    count_on();
    `CHK("shutdown", 0, n0 + n1)
    $display("test modulation done");

    // Fades with the shortest step: wake, shutdown, cancel by a write
    wr(`LGR_ADDR_GLOBAL, 8'h11);
    count_on();
    `CHK("fade in start", 1, int'(n0 < 64))
    wait_cyc(17 * 16 * MsCyc);
    count_on();
    `CHK("fade in end", 256, n0)
    wr(`LGR_ADDR_GLOBAL, 8'h01);
    count_on();
    `CHK("fade out start", 1, int'(n0 > 128))
    wr(`LGR_ADDR_INTENS0, 8'h80);
    wait_cyc(300);
    count_on();
    `CHK("fade cancel", 0, n0)
    $display("test fade done");

    // Blink of 64 ms at half duty: two whole periods hold 2 or 3 on-periods each
    wr(`LGR_ADDR_GLOBAL, 8'h10);
    wr(`LGR_ADDR_INTENS0, 8'hFF);
    wr(`LGR_ADDR_SETUP0, 8'h07);
    wait_cyc(300);
    cnt = 0;
    repeat (10)
    begin
      count_on();
      cnt += n0;
    end
    `CHK("blink half", 1, int'(cnt == 1024 || cnt == 1536))
    $display("test blink done");
    give_verdict();
  end
endmodule
`default_nettype wire
